/* File: rtl/isoio_port_decoder.sv */
// Purpose: Host bus control logic for an eight-input, eight-relay I/O card
// Assumes: Host strobes synchronous to core_clk_in, one cycle per access
// Notes:   Relay, enable, pending and filter flags clear at reset
`timescale 1ns/1ps
module isoio_port_decoder
  import isoio_pkg::*;
#(
  parameter int NUM_IO = ISOIO_DATA_W
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    reset_in,
  input  wire logic [ISOIO_ADDR_W-1:0] addr_in,
  input  wire logic                    io_rd_in,
  input  wire logic                    io_wr_in,
  input  wire logic [NUM_IO-1:0]       data_in,
  output logic      [NUM_IO-1:0]       data_out,
  output logic                         data_oe_out,
  input  wire logic [7:0]              address_select_switches_in,
  input  wire logic [NUM_IO-1:0]       filter_select_switches_in,
  input  wire logic [NUM_IO-1:0]       input_bit_in,
  input  wire logic                    irq_jumper_in,
  output logic      [NUM_IO-1:0]       relay_bit_out,
  output logic      [NUM_IO-1:0]       filter_on_out,
  output logic                         irq_out,
  output logic                         irq_enable_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Switch ON reads as 1 here and asks for address 0
  function automatic logic isoio_hit(input logic [ISOIO_ADDR_W-1:0] a,
                                     input logic [7:0]              sw);
    return a[ISOIO_BASE_MSB:ISOIO_BASE_LSB] == ~sw;
  endfunction : isoio_hit

  logic                   hit;
  logic [ISOIO_SEL_W-1:0] sel;
  logic                   rd_hit;
  logic                   wr_hit;
  logic [NUM_IO-1:0]      in_sync;
  logic                   in_change;
  logic                   filter_flag;
  logic                   irq_pending;

  assign hit    = isoio_hit(addr_in, address_select_switches_in);
  assign sel    = addr_in[ISOIO_SEL_W-1:0];
  assign rd_hit = hit && io_rd_in;
  assign wr_hit = hit && io_wr_in && !io_rd_in;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser and change detector
  isoio_in_sync #(.WIDTH(NUM_IO)) i_isoio_in_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .level_in    (input_bit_in),
    .level_out   (in_sync),
    .change_out  (in_change)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Relay drive latch
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      relay_bit_out <= ISOIO_RELAY_RST;
    end else if (wr_hit && sel == ISOIO_OFS_RELAY) begin
      relay_bit_out <= data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the strobe
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      data_out    <= ISOIO_ZERO_BYTE;
      data_oe_out <= 1'b0;
    end else begin
      data_oe_out <= rd_hit;
      if (rd_hit) begin
        case (sel)
          ISOIO_OFS_RELAY: data_out <= relay_bit_out;
          ISOIO_OFS_INPUT: data_out <= in_sync;
          default:         data_out <= ISOIO_ZERO_BYTE;
        endcase
      end else begin
        data_out <= ISOIO_ZERO_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_enable_out <= 1'b0;
    end else if (rd_hit && sel == ISOIO_OFS_IRQ) begin
      irq_enable_out <= 1'b1;
    end else if (wr_hit && sel == ISOIO_OFS_IRQ) begin
      irq_enable_out <= 1'b0;
    end
  end

  // Pending flag: a change in the clear cycle wins
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_pending <= 1'b0;
    end else if (irq_enable_out && in_change) begin
      irq_pending <= 1'b1;
    end else if (wr_hit && sel == ISOIO_OFS_INPUT) begin
      irq_pending <= 1'b0;
    end else if (!irq_enable_out) begin
      irq_pending <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_pending && irq_enable_out && irq_jumper_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global filter flag and per-channel filter select
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      filter_flag <= 1'b0;
    end else if (rd_hit && sel == ISOIO_OFS_FILTER) begin
      filter_flag <= 1'b1;
    end else if (wr_hit && sel == ISOIO_OFS_FILTER) begin
      filter_flag <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_IO; g++) begin : g_filt
      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          filter_on_out[g] <= 1'b0;
        end else begin
          filter_on_out[g] <= filter_select_switches_in[g] || filter_flag;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_wr(logic [1:0] o);
    wr_hit && sel == o;
  endsequence

  sequence s_rd(logic [1:0] o);
    rd_hit && sel == o;
  endsequence

  sequence s_irq_quiet;
    !irq_enable_out ##1 !irq_out;
  endsequence

  property p_relay_write;
    @(posedge core_clk_in) disable iff (reset_in)
    s_wr(ISOIO_OFS_RELAY) |=> relay_bit_out == $past(data_in);
  endproperty
  a_relay_write: assert property (p_relay_write) else $error("relay latch wrong");

  property p_relay_read;
    @(posedge core_clk_in) disable iff (reset_in)
    s_rd(ISOIO_OFS_RELAY) |=> data_oe_out && data_out == $past(relay_bit_out);
  endproperty
  a_relay_read: assert property (p_relay_read) else $error("relay readback wrong");

  property p_input_read;
    @(posedge core_clk_in) disable iff (reset_in)
    s_rd(ISOIO_OFS_INPUT) |=> data_out == $past(in_sync);
  endproperty
  a_input_read: assert property (p_input_read) else $error("input read wrong");

  property p_strobe_zero;
    @(posedge core_clk_in) disable iff (reset_in)
    (rd_hit && sel[1]) |=> data_out == ISOIO_ZERO_BYTE;
  endproperty
  a_strobe_zero: assert property (p_strobe_zero) else $error("strobe read not zero");

  property p_irq_en;
    @(posedge core_clk_in) disable iff (reset_in)
    s_rd(ISOIO_OFS_IRQ) |=> irq_enable_out;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("enable not set");

  property p_irq_dis;
    @(posedge core_clk_in) disable iff (reset_in)
    s_wr(ISOIO_OFS_IRQ) |=> s_irq_quiet;
  endproperty
  a_irq_dis: assert property (p_irq_dis) else $error("irq after disable");

  property p_change_irq;
    @(posedge core_clk_in) disable iff (reset_in)
    (irq_enable_out && in_change && irq_jumper_in
       && !(wr_hit && sel == ISOIO_OFS_IRQ))
      |=> ##1 (irq_out || !$past(irq_jumper_in, 1) || !irq_enable_out);
  endproperty
  a_change_irq: assert property (p_change_irq) else $error("change missed");

  property p_clear;
    @(posedge core_clk_in) disable iff (reset_in)
    (wr_hit && sel == ISOIO_OFS_INPUT && !in_change) |=> ##1 !irq_out;
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");

  property p_jumper;
    @(posedge core_clk_in) disable iff (reset_in)
    !irq_jumper_in |=> !irq_out;
  endproperty
  a_jumper: assert property (p_jumper) else $error("irq without jumper");

  property p_filter;
    @(posedge core_clk_in) disable iff (reset_in)
    s_rd(ISOIO_OFS_FILTER) |=> ##1 (filter_on_out == '1);
  endproperty
  a_filter: assert property (p_filter) else $error("filter not global");

  property p_filter_off;
    @(posedge core_clk_in) disable iff (reset_in)
    s_wr(ISOIO_OFS_FILTER) |=> ##1 (filter_on_out == $past(filter_select_switches_in));
  endproperty
  a_filter_off: assert property (p_filter_off) else $error("filter not per switch");

  ////////////////////////////////////////////////////////////////////////////
  // Decode and data path checks
  property p_hit_read;
    @(posedge core_clk_in) disable iff (reset_in)
    (io_rd_in && addr_in[ISOIO_BASE_MSB:ISOIO_BASE_LSB] == ~address_select_switches_in)
      |=> data_oe_out;
  endproperty
  a_hit_read: assert property (p_hit_read) else $error("decoded read not answered");

  property p_foreign_read;
    @(posedge core_clk_in) disable iff (reset_in)
    (io_rd_in && addr_in[ISOIO_BASE_MSB:ISOIO_BASE_LSB] != ~address_select_switches_in)
      |=> !data_oe_out;
  endproperty
  a_foreign_read: assert property (p_foreign_read) else $error("foreign read answered");

  property p_foreign_write;
    @(posedge core_clk_in) disable iff (reset_in)
    (io_wr_in && addr_in[ISOIO_BASE_MSB:ISOIO_BASE_LSB] != ~address_select_switches_in)
      |=> $stable(relay_bit_out) && $stable(irq_enable_out) && $stable(filter_flag);
  endproperty
  a_foreign_write: assert property (p_foreign_write) else $error("foreign write taken");

  property p_reg_select;
    @(posedge core_clk_in) disable iff (reset_in)
    (wr_hit && sel != ISOIO_OFS_RELAY) |=> $stable(relay_bit_out);
  endproperty
  a_reg_select: assert property (p_reg_select) else $error("relay hit by other offset");

  property p_read_keeps;
    @(posedge core_clk_in) disable iff (reset_in)
    rd_hit |=> $stable(relay_bit_out);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read changed relays");

  property p_oe_source;
    @(posedge core_clk_in) disable iff (reset_in)
    data_oe_out |-> $past(rd_hit);
  endproperty
  a_oe_source: assert property (p_oe_source) else $error("data driven without read");

  property p_idle_zero;
    @(posedge core_clk_in) disable iff (reset_in)
    !data_oe_out |-> data_out == ISOIO_ZERO_BYTE;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle data not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, checked without the reset disable
  property p_reset_relay;
    @(posedge core_clk_in)
    reset_in |=> relay_bit_out == ISOIO_RELAY_RST;
  endproperty
  a_reset_relay: assert property (p_reset_relay) else $error("relays not cleared");

  property p_reset_flags;
    @(posedge core_clk_in)
    reset_in |=> !irq_enable_out && !irq_pending && !filter_flag && !irq_out;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flags not cleared");

  // Interrupt path and channel filter checks
  property p_change_detect;
    @(posedge core_clk_in) disable iff (reset_in)
    (!$past(reset_in) && in_sync != $past(in_sync)) |=> in_change;
  endproperty
  a_change_detect: assert property (p_change_detect) else $error("input change not seen");

  property p_pend_hold;
    @(posedge core_clk_in) disable iff (reset_in)
    (irq_pending && irq_enable_out && !(wr_hit && sel == ISOIO_OFS_INPUT)
       && !(wr_hit && sel == ISOIO_OFS_IRQ)) |=> irq_pending;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending lost");

  property p_set_wins;
    @(posedge core_clk_in) disable iff (reset_in)
    (irq_enable_out && in_change && wr_hit && sel == ISOIO_OFS_INPUT) |=> irq_pending;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("change lost to clear");

  property p_clear_keeps_en;
    @(posedge core_clk_in) disable iff (reset_in)
    s_wr(ISOIO_OFS_INPUT) |=> irq_enable_out == $past(irq_enable_out);
  endproperty
  a_clear_keeps_en: assert property (p_clear_keeps_en) else $error("clear touched enable");

  property p_irq_source;
    @(posedge core_clk_in) disable iff (reset_in)
    irq_out |-> $past(irq_pending) && $past(irq_enable_out) && $past(irq_jumper_in);
  endproperty
  a_irq_source: assert property (p_irq_source) else $error("irq without cause");

  property p_filter_or;
    @(posedge core_clk_in) disable iff (reset_in)
    !$past(reset_in) |-> filter_on_out ==
      ($past(filter_select_switches_in) | {NUM_IO{$past(filter_flag)}});
  endproperty
  a_filter_or: assert property (p_filter_or) else $error("channel filter not or");

endmodule : isoio_port_decoder

/* File: rtl/isoio_pkg.sv */
// Purpose: Shared constants for the isolated I/O port decoder
// Assumes: Byte-wide host I/O bus, ten address lines
// Notes:   Offsets are the low two address bits
package isoio_pkg;
  localparam int        ISOIO_DATA_W     = 8;
  localparam int        ISOIO_ADDR_W     = 10;
  localparam int        ISOIO_SEL_W      = 2;
  localparam int        ISOIO_BASE_LSB   = 2;
  localparam int        ISOIO_BASE_MSB   = 9;
  localparam logic [1:0] ISOIO_OFS_RELAY  = 2'h0;
  localparam logic [1:0] ISOIO_OFS_INPUT  = 2'h1;
  localparam logic [1:0] ISOIO_OFS_IRQ    = 2'h2;
  localparam logic [1:0] ISOIO_OFS_FILTER = 2'h3;
  localparam logic [7:0] ISOIO_RELAY_RST  = 8'h00;
  localparam logic [7:0] ISOIO_ZERO_BYTE  = 8'h00;
  localparam logic [7:0] ISOIO_SW_DEFAULT = 8'h3f;
endpackage : isoio_pkg

/* File: rtl/isoio_in_sync.sv */
// Purpose: Two-stage synchroniser and change detector for input levels
// Assumes: Inputs are asynchronous isolated levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module isoio_in_sync
  import isoio_pkg::*;
#(
  parameter int WIDTH = ISOIO_DATA_W
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] level_out,
  output logic                  change_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;
  logic             primed;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      meta      <= '0;
      level_out <= '0;
    end else begin
      meta      <= level_in;
      level_out <= meta;
    end
  end

  // Previous sample; first sample after reset is not a change
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      prev       <= '0;
      primed     <= 1'b0;
      change_out <= 1'b0;
    end else begin
      prev       <= level_out;
      primed     <= 1'b1;
      change_out <= primed && (prev != level_out);
    end
  end
endmodule : isoio_in_sync

/* File: tb/isoio_host_model.sv */
// Purpose: Host bus model issuing byte I/O cycles
// Assumes: Strobe taken on the edge after it rises
// Notes:   Released address and data lines show the inverse of the last value, strobes go low
`timescale 1ns/1ps
module isoio_host_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rdata_oe_in,
  output logic      [9:0] addr_out,
  output logic            io_rd_out,
  output logic            io_wr_out,
  output logic      [7:0] wdata_out
);
  initial begin
    addr_out = 10'h000;
    io_rd_out = 1'b0;
    io_wr_out = 1'b0;
    wdata_out = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One-cycle strobe, then release
  task automatic cycle(input logic [9:0] a, input logic [7:0] d, input logic rd);
    @(posedge core_clk_in);
    addr_out <= a;
    wdata_out <= d;
    io_rd_out <= rd;
    io_wr_out <= ~rd;
    @(posedge core_clk_in);
    addr_out <= ~a;
    wdata_out <= ~d;
    io_rd_out <= 1'b0;
    io_wr_out <= 1'b0;
  endtask : cycle
  task automatic io_write(input logic [9:0] a, input logic [7:0] d);
    cycle(a, d, 1'b0);
  endtask : io_write
  task automatic io_read(input logic [9:0] a, output logic [7:0] d, output bit ok);
    cycle(a, 8'h00, 1'b1);
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 3 && !ok; i++) begin
      @(posedge core_clk_in);
      if (rdata_oe_in === 1'b1) begin
        ok = 1'b1;
        d = rdata_in;
      end
    end
  endtask : io_read
endmodule : isoio_host_model

/* File: tb/isoio_port_decoder_bench.sv */
// Purpose: Self-checking bench for the port decoder
// Assumes: Host model drives the bus side
// Notes:   Fixed switch settings per pass
`timescale 1ns/1ps
module isoio_port_decoder_bench;
  import isoio_pkg::*;
  logic       core_clk_in, reset_in, io_rd, io_wr, oe, irq, irqen, jmp;
  logic [9:0] addr, base;
  logic [7:0] wdata, rdata, relay, filt, sw, fsw, inp, d;
  logic [7:0] sws [2] = '{8'h3f, 8'h00};
  logic [7:0] pats [2] = '{8'h81, 8'h5a};
  bit         ok;
  int         mismatches, n_tests;
  isoio_port_decoder i_isoio_port_decoder (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .addr_in(addr), .io_rd_in(io_rd), .io_wr_in(io_wr), .data_in(wdata), .data_out(rdata),
    .data_oe_out(oe), .address_select_switches_in(sw), .filter_select_switches_in(fsw),
    .input_bit_in(inp), .irq_jumper_in(jmp), .relay_bit_out(relay), .filter_on_out(filt),
    .irq_out(irq), .irq_enable_out(irqen));
  isoio_host_model i_isoio_host_model (.core_clk_in(core_clk_in), .rdata_in(rdata),
    .rdata_oe_in(oe), .addr_out(addr), .io_rd_out(io_rd), .io_wr_out(io_wr),
    .wdata_out(wdata));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Compares %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] ofs, input logic [7:0] v);
    i_isoio_host_model.io_write(base + 10'(ofs), v);
  endtask : wr
  task automatic rd_chk(input logic [1:0] ofs, input logic [7:0] exp, input string msg);
    i_isoio_host_model.io_read(base + 10'(ofs), d, ok);
    chk({7'h00, ok}, 8'h01, msg);
    if (!ok) wrap_up();
    chk(d, exp, msg);
  endtask : rd_chk
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 12 && irq !== exp; i++) @(posedge core_clk_in);
    chk({7'h00, irq}, {7'h00, exp}, "irq level");
    if (irq !== exp) wrap_up();
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sw = 8'h3f;
    fsw = 8'h05;
    inp = 8'h00;
    jmp = 1'b1;
    reset_in = 1'b1;
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    chk(relay, 8'h00, "relay reset");
    chk({6'h00, irq, irqen}, 8'h00, "irq reset");
    foreach (sws[k]) begin
      @(posedge core_clk_in);
      sw <= sws[k];
      base = {~sws[k], 2'b00};
      wr(2'h0, pats[k]);
      rd_chk(2'h0, pats[k], "relay readback");
      chk(relay, pats[k], "relay pins");
      i_isoio_host_model.io_write(base + 10'h004, 8'hff);
      @(posedge core_clk_in);
      chk(relay, pats[k], "outside write");
      i_isoio_host_model.io_read(base ^ 10'h200, d, ok);
      chk({7'h00, ok}, 8'h00, "foreign read");
    end
    $display("Test decode done");
    inp <= 8'ha5;
    repeat (5) @(posedge core_clk_in);
    rd_chk(2'h1, 8'ha5, "inputs");
    chk(filt, fsw, "switch filters");
    rd_chk(2'h3, 8'h00, "filter strobe");
    repeat (2) @(posedge core_clk_in);
    chk(filt, 8'hff, "global filter");
    wr(2'h3, 8'h00);
    repeat (3) @(posedge core_clk_in);
    chk(filt, fsw, "filter cleared");
    $display("Test filter done");
    rd_chk(2'h2, 8'h00, "enable strobe");
    chk({7'h00, irqen}, 8'h01, "irq enabled");
    jmp <= 1'b0;
    inp <= 8'ha4;
    repeat (12) @(posedge core_clk_in);
    chk({7'h00, irq}, 8'h00, "no jumper");
    jmp <= 1'b1;
    wait_irq(1'b1);
    wr(2'h1, 8'h3c);
    wait_irq(1'b0);
    // Clear lands in the cycle the change is seen
    inp <= 8'ha6;
    repeat (2) @(posedge core_clk_in);
    wr(2'h1, 8'h00);
    wait_irq(1'b1);
    wr(2'h1, 8'h00);
    wait_irq(1'b0);
    wr(2'h2, 8'hff);
    @(posedge core_clk_in);
    chk({7'h00, irqen}, 8'h00, "irq disabled");
    inp <= 8'ha5;
    repeat (12) @(posedge core_clk_in);
    chk({7'h00, irq}, 8'h00, "disabled change");
    $display("Test interrupt done");
    wr(2'h0, 8'h3c);
    rd_chk(2'h2, 8'h00, "enable again");
    rd_chk(2'h3, 8'h00, "filter again");
    reset_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    chk(relay, 8'h00, "relay mid reset");
    chk({6'h00, irq, irqen}, 8'h00, "irq mid reset");
    @(posedge core_clk_in);
    chk(filt, fsw, "filter mid reset");
    rd_chk(2'h0, 8'h00, "relay after reset");
    $display("Test reset done");
    wrap_up();
  end
endmodule : isoio_port_decoder_bench
